//--- flash_array_model.sv
// behavioural program flash array on the far side of the programming unit
// assumes one request at a time, held high until the done pulse is seen
`timescale 1ns/1ps
module flash_array_model #(
   parameter int LAT = 6 // request to done in cycles, arbitrary
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire flash_prog_pkg::word_t addr_i,
   output logic done_o,
   output flash_prog_pkg::word_t rdata_o
);
   import flash_prog_pkg::*;
   // ---------------------------------------------
   // array timing
   // ---------------------------------------------
   int cnt; // cycles spent on the current request
   initial done_o = 1'b0;
   initial rdata_o = 16'h0F0F;
   // slow answer so the idle flag is seen low
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      rdata_o <= ~rdata_o; // data wobbles outside done, never a stale match
      if (rst_i) begin
         cnt <= 0;
      end else if (req_i && !done_o) begin
         cnt <= cnt + 1;
         if (cnt == LAT - 1) begin
            done_o <= 1'b1;
            rdata_o <= addr_i ^ 16'hC35A; // contents: scrambled address
            cnt <= 0;
         end
      end
   end
endmodule

//--- flash_op_engine.sv
// flash engine: hands one operation at a time to the program flash array
// assumes the array answers each request with one done pulse on the same clock
`timescale 1ns/1ps
`include "flash_prog_unit_regs.svh"
module flash_op_engine (
   input wire logic clk_i,
   input wire logic rst_i,
   flash_op_if.engine ops,
   input wire logic flash_done_i,
   input wire flash_prog_pkg::word_t flash_rdata_i,
   output logic flash_req_o,
   output logic [1:0] flash_cmd_o,
   output flash_prog_pkg::word_t flash_addr_o,
   output flash_prog_pkg::word_t flash_wdata_o,
   output logic flash_byte_o
);
   import flash_prog_pkg::*;

   // ---------------------------------------------------------------
   // request toward the array
   // ---------------------------------------------------------------
   eng_state_t state_reg; // engine phase
   logic done_reg; // completion pulse
   word_t rdata_reg; // captured read data

   // the front end only launches while idle, so a start is never dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ENG_IDLE;
         flash_req_o <= 1'b0;
         flash_cmd_o <= `TASK_READ;
         flash_addr_o <= 16'h0000;
         flash_wdata_o <= 16'h0000;
         flash_byte_o <= 1'b1;
         done_reg <= 1'b0;
         rdata_reg <= 16'h0000;
      end else begin
         done_reg <= 1'b0;
         case (state_reg)
            ENG_IDLE: begin
               if (ops.start) begin
                  // request stays high until the array answers
                  state_reg <= ENG_WAIT;
                  flash_req_o <= 1'b1;
                  flash_cmd_o <= ops.cmd;
                  flash_addr_o <= ops.addr;
                  flash_wdata_o <= ops.wdata;
                  flash_byte_o <= ops.byte_mode;
               end
            end
            default: begin
               if (flash_done_i) begin
                  state_reg <= ENG_IDLE;
                  flash_req_o <= 1'b0;
                  done_reg <= 1'b1;
                  rdata_reg <= flash_rdata_i;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // answers to the front end
   // ---------------------------------------------------------------
   assign ops.busy = (state_reg == ENG_WAIT) || ops.start;
   assign ops.done = done_reg;
   assign ops.done_cmd = flash_cmd_o;
   assign ops.rdata = rdata_reg;

   // the request must fall once the array has answered
   req_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flash_req_o && flash_done_i |=> !flash_req_o && done_reg) // see [RQ23]
      else $error("request not released on done");
endmodule

//--- flash_op_if.sv
// carrier between the register front end and the flash engine
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface flash_op_if;
   logic start; // one-cycle launch pulse
   logic [1:0] cmd; // task code of the launched operation
   logic [15:0] addr; // byte address toward the array
   logic [15:0] wdata; // data to program
   logic byte_mode; // one byte instead of one word
   logic busy; // engine waits on the array
   logic done; // one-cycle completion pulse
   logic [1:0] done_cmd; // task code that just finished
   logic [15:0] rdata; // data returned by a read
   modport ctrl (output start, cmd, addr, wdata, byte_mode, input busy, done, done_cmd, rdata);
   modport engine (input start, cmd, addr, wdata, byte_mode, output busy, done, done_cmd, rdata);
endinterface

//--- flash_prog_pkg.sv
// types shared by the flash programming unit modules
// assumes the register header sits in the same folder
package flash_prog_pkg;
   typedef logic [7:0] byte_t; // one special-function register
   typedef logic [15:0] word_t; // flash word or byte address
   typedef enum logic [1:0] {LK_PROT, LK_STEP1, LK_OPEN, LK_DEAD} lock_t; // unlock progress
   typedef enum logic {ENG_IDLE, ENG_WAIT} eng_state_t; // flash engine phases
endpackage

//--- flash_prog_unit_regs.svh
// register offsets, reset values, field positions and codes of the flash programming unit
// assumes it is included by bare name from the design modules and the bench
`ifndef FLASH_PROG_UNIT_REGS_SVH
`define FLASH_PROG_UNIT_REGS_SVH

// ---------------------------------------------------------------
// special-function register offsets
// ---------------------------------------------------------------
`define CFG_OFS 8'hE9
`define ADDR_LO_OFS 8'hEA
`define ADDR_HI_OFS 8'hEB
`define DATA_LO_OFS 8'hEC
`define DATA_HI_OFS 8'hED
`define CLK_RANGE_OFS 8'hEE

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CFG_RST 8'h34
`define ADDR_RST 8'h00
`define DATA_RST 8'h00
`define CLK_RANGE_RST 4'h0

// ---------------------------------------------------------------
// configuration register fields
// ---------------------------------------------------------------
`define LOCK_MSB 7
`define LOCK_LSB 6
`define IDLE_BIT 5
`define READY_BIT 4
`define BYTE_BIT 2
`define TASK_MSB 1
`define TASK_LSB 0

// ---------------------------------------------------------------
// field codes
// ---------------------------------------------------------------
`define TASK_READ 2'h0
`define TASK_MASS 2'h1
`define TASK_PAGE 2'h2
`define TASK_WRITE 2'h3
`define LOCK_CODE_PROT 2'h0
`define LOCK_CODE_STEP1 2'h1
`define LOCK_CODE_OPEN 2'h2
`define LOCK_CODE_DEAD 2'h3
`define UNLOCK_FIRST 8'hAA
`define UNLOCK_SECOND 8'h55
`define PAGE_LSB_ZERO 9'h000

`endif

//--- flash_program_interface.sv
// flash programming unit: special-function registers, unlock guard, write buffer
// assumes the processor register port and the flash array share clk_i
//
// Function
// [RQ1] work only while the enable input is high; a buffered write still drains while it is low
// [RQ2] read, page erase, mass erase, write
// [RQ3] byte mode and word mode transfers
// [RQ4] address steps after each read or write
// [RQ5] lock stage field advances on AA, 55
// [RQ6] wrong sequence locks until reset
// [RQ7] idle flag high when nothing pending
// [RQ8] ready means idle, or buffer free
// [RQ9] config bit 2 selects byte mode
// [RQ10] bits 1:0 select the operation
// [RQ11] start only when ready, else cancel
// [RQ12] software checks idle before requests
// [RQ13] software unlocks, paces writes on ready
// [RQ14] byte mode: 16-bit address, data low
// [RQ15] word mode: 15-bit word address
// [RQ16] word mode uses both data registers
// [RQ17] page erase: page in high address
// [RQ18] data high holds upper read/write byte
// [RQ19] data low write launches flash write
// [RQ20] software sets the clock range register
// [RQ21] unlock before each write or erase; the code takes more writes until a finished job relocks
// [RQ22] page erase clears 512 byte addresses
// [RQ23] idle stays low until array finishes
// [RQ24] finished write or erase relocks unit; the code skips the relock when a write or erase is accepted in that same cycle
`timescale 1ns/1ps
`include "flash_prog_unit_regs.svh"
module flash_program_interface (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire flash_prog_pkg::byte_t sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire flash_prog_pkg::byte_t sfr_wdata_i,
   input wire logic unit_enable_i,
   input wire logic flash_done_i,
   input wire flash_prog_pkg::word_t flash_rdata_i,
   output flash_prog_pkg::byte_t sfr_rdata_o,
   output logic flash_req_o,
   output logic [1:0] flash_cmd_o,
   output flash_prog_pkg::word_t flash_addr_o,
   output flash_prog_pkg::word_t flash_wdata_o,
   output logic flash_byte_o,
   output logic [3:0] flash_clk_range_o
);
   import flash_prog_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // register hit test, used by every decode
   function automatic logic hit(input byte_t addr, input byte_t ofs);
      hit = (addr == ofs);
   endfunction

   // byte address toward the array for a task
   function automatic word_t array_addr(input logic [1:0] task_code, input logic byte_sel,
                                        input byte_t hi, input byte_t lo);
      word_t a;
      a = 16'h0000;
      if (task_code == `TASK_MASS) begin
         a = 16'h0000;
      end else if (task_code == `TASK_PAGE) begin
         a = {hi[6:0], `PAGE_LSB_ZERO};
      end else if (byte_sel) begin
         a = {hi, lo};
      end else begin
         a = {hi[6:0], lo, 1'b0};
      end
      array_addr = a;
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   flash_op_if ops (); // front end to engine
   lock_t lock_reg; // unlock progress
   lock_t lock_next;
   logic byte_reg; // transfer width select
   logic [1:0] task_reg; // selected operation
   byte_t addr_lo_reg; // operation address, low
   byte_t addr_hi_reg; // operation address, high
   byte_t data_lo_reg; // write data or last read byte
   byte_t data_hi_reg; // upper byte of the word
   logic [3:0] clk_range_reg; // array timing range
   logic buf_full_reg; // second write waiting
   word_t buf_addr_reg; // its address
   word_t buf_data_reg; // its data
   logic buf_byte_reg; // its width
   logic start_reg; // launch pulse
   logic [1:0] cmd_reg; // launched task
   word_t op_addr_reg; // launched address
   word_t op_data_reg; // launched data
   logic op_byte_reg; // launched width

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire wr_cfg = sfr_wr_i && hit(sfr_addr_i, `CFG_OFS);
   wire wr_alo = sfr_wr_i && hit(sfr_addr_i, `ADDR_LO_OFS);
   wire wr_ahi = sfr_wr_i && hit(sfr_addr_i, `ADDR_HI_OFS);
   wire wr_dlo = sfr_wr_i && hit(sfr_addr_i, `DATA_LO_OFS);
   wire wr_dhi = sfr_wr_i && hit(sfr_addr_i, `DATA_HI_OFS);
   wire wr_clk = sfr_wr_i && hit(sfr_addr_i, `CLK_RANGE_OFS);
   wire [1:0] new_task = sfr_wdata_i[`TASK_MSB:`TASK_LSB];
   // data low bytes consumed by the unlock sequence never reach the array
   wire unlock_byte = wr_dlo && ((lock_reg == LK_PROT && sfr_wdata_i == `UNLOCK_FIRST)
                      || lock_reg == LK_STEP1); // see [RQ5]
   wire write_req = wr_dlo && task_reg == `TASK_WRITE && !unlock_byte; // see [RQ19]
   wire erase_req = wr_cfg && (new_task == `TASK_MASS || new_task == `TASK_PAGE); // see [RQ2]
   wire read_req = wr_cfg && new_task == `TASK_READ; // see [RQ10]
   wire busy = ops.busy || start_reg;
   // in write mode ready means the second buffer is free
   wire ready = (task_reg == `TASK_WRITE) ? !buf_full_reg : !busy; // see [RQ8]
   // idle only once returned data has landed and no write waits
   wire idle = !busy && !buf_full_reg && !ops.done; // see [RQ7] [RQ23]
   wire is_open = lock_reg == LK_OPEN;
   // a task change out of write mode must not launch over a write in flight or waiting
   wire engine_free = !busy && !buf_full_reg;
   wire read_acc = read_req && ready && engine_free && unit_enable_i; // see [RQ1] [RQ11]
   wire erase_acc = erase_req && ready && engine_free && unit_enable_i && is_open; // see [RQ11]
   wire write_acc = write_req && ready && unit_enable_i && is_open; // see [RQ11]
   wire [1:0] acc_task = wr_cfg ? new_task : task_reg;
   wire acc_byte = wr_cfg ? sfr_wdata_i[`BYTE_BIT] : byte_reg; // see [RQ9]
   wire word_t acc_addr = array_addr(acc_task, acc_byte, addr_hi_reg, addr_lo_reg); // see [RQ14] [RQ15] [RQ22]
   wire word_t acc_data = {data_hi_reg, sfr_wdata_i}; // see [RQ16] [RQ18]
   // a write goes straight out only when the engine is free
   wire write_now = write_acc && !busy;
   wire drain = buf_full_reg && !busy;
   wire launch = read_acc || erase_acc || write_now || drain;
   wire step_addr = read_acc || write_acc; // see [RQ4]
   wire word_t addr_cur = {addr_hi_reg, addr_lo_reg};
   wire word_t addr_inc = byte_reg ? 16'(addr_cur + 16'h0001)
                                   : {1'b0, 15'(addr_cur[14:0] + 15'h0001)}; // see [RQ3]
   wire relock = ops.done && ops.done_cmd != `TASK_READ;
   wire byte_t cfg_view = {lock_reg, idle, ready, 1'b0, byte_reg, task_reg};
   wire byte_t rd_mux = hit(sfr_addr_i, `CFG_OFS) ? cfg_view :
                        hit(sfr_addr_i, `ADDR_LO_OFS) ? addr_lo_reg :
                        hit(sfr_addr_i, `ADDR_HI_OFS) ? addr_hi_reg :
                        hit(sfr_addr_i, `DATA_LO_OFS) ? data_lo_reg :
                        hit(sfr_addr_i, `DATA_HI_OFS) ? data_hi_reg :
                        hit(sfr_addr_i, `CLK_RANGE_OFS) ? {4'h0, clk_range_reg} : 8'h00;

   // ---------------------------------------------------------------
   // unlock guard
   // ---------------------------------------------------------------
   // a locked-out unit stays so until reset; guarded requests while shut and enabled lock it out
   always_comb begin
      lock_next = lock_reg;
      if (lock_reg == LK_DEAD) begin
         lock_next = LK_DEAD; // see [RQ6]
      end else if (!unit_enable_i) begin
         lock_next = relock ? LK_PROT : lock_reg; // a finished job still relocks, see [RQ24]
      end else if (wr_dlo && lock_reg == LK_PROT && sfr_wdata_i == `UNLOCK_FIRST) begin
         lock_next = LK_STEP1; // see [RQ5]
      end else if (wr_dlo && lock_reg == LK_STEP1) begin
         lock_next = (sfr_wdata_i == `UNLOCK_SECOND) ? LK_OPEN : LK_DEAD; // see [RQ5] [RQ6]
      end else if ((write_req || erase_req) && !is_open) begin
         lock_next = LK_DEAD; // see [RQ6]
      end else if (relock && !write_acc && !erase_acc) begin
         lock_next = LK_PROT; // see [RQ24]
      end
   end

   // ---------------------------------------------------------------
   // configuration and lock registers
   // ---------------------------------------------------------------
   // status bits are computed, only lock, width, task and clock range are stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_reg <= LK_PROT;
         byte_reg <= 1'b1;
         task_reg <= `TASK_READ;
         clk_range_reg <= `CLK_RANGE_RST;
      end else begin
         lock_reg <= lock_next;
         if (wr_cfg) begin
            byte_reg <= sfr_wdata_i[`BYTE_BIT]; // see [RQ9]
            task_reg <= new_task; // see [RQ10]
         end
         if (wr_clk) begin
            clk_range_reg <= sfr_wdata_i[3:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // address registers
   // ---------------------------------------------------------------
   // a software write in the same cycle beats the automatic step
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_lo_reg <= `ADDR_RST;
         addr_hi_reg <= `ADDR_RST;
      end else begin
         if (wr_alo) begin
            addr_lo_reg <= sfr_wdata_i;
         end else if (step_addr) begin
            addr_lo_reg <= addr_inc[7:0]; // see [RQ4]
         end
         if (wr_ahi) begin
            addr_hi_reg <= sfr_wdata_i;
         end else if (step_addr) begin
            addr_hi_reg <= addr_inc[15:8]; // see [RQ4]
         end
      end
   end

   // ---------------------------------------------------------------
   // data registers
   // ---------------------------------------------------------------
   // returned read data wins over a software write in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_lo_reg <= `DATA_RST;
         data_hi_reg <= `DATA_RST;
      end else if (ops.done && ops.done_cmd == `TASK_READ) begin
         data_lo_reg <= ops.rdata[7:0]; // see [RQ14]
         if (!op_byte_reg) begin
            data_hi_reg <= ops.rdata[15:8]; // see [RQ16] [RQ18]
         end
      end else begin
         if (wr_dlo) begin
            data_lo_reg <= sfr_wdata_i;
         end
         if (wr_dhi) begin
            data_hi_reg <= sfr_wdata_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // double buffer for writes
   // ---------------------------------------------------------------
   // one write may wait behind the one in flight; a third is cancelled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buf_full_reg <= 1'b0;
         buf_addr_reg <= 16'h0000;
         buf_data_reg <= 16'h0000;
         buf_byte_reg <= 1'b1;
      end else if (write_acc && busy) begin
         buf_full_reg <= 1'b1;
         buf_addr_reg <= acc_addr;
         buf_data_reg <= acc_data;
         buf_byte_reg <= byte_reg;
      end else if (drain) begin
         buf_full_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // launch toward the engine
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_reg <= 1'b0;
         cmd_reg <= `TASK_READ;
         op_addr_reg <= 16'h0000;
         op_data_reg <= 16'h0000;
         op_byte_reg <= 1'b1;
      end else begin
         start_reg <= launch;
         if (drain) begin
            cmd_reg <= `TASK_WRITE;
            op_addr_reg <= buf_addr_reg;
            op_data_reg <= buf_data_reg;
            op_byte_reg <= buf_byte_reg;
         end else if (launch) begin
            cmd_reg <= acc_task;
            op_addr_reg <= acc_addr;
            op_data_reg <= acc_data;
            op_byte_reg <= acc_byte;
         end
      end
   end

   assign ops.start = start_reg;
   assign ops.cmd = cmd_reg;
   assign ops.addr = op_addr_reg;
   assign ops.wdata = op_data_reg;
   assign ops.byte_mode = op_byte_reg;

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------
   // read data is registered, so it appears one edge after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i) begin
         sfr_rdata_o <= rd_mux;
      end
   end

   assign flash_clk_range_o = clk_range_reg;

   flash_op_engine engine (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ops(ops),
      .flash_done_i(flash_done_i),
      .flash_rdata_i(flash_rdata_i),
      .flash_req_o(flash_req_o),
      .flash_cmd_o(flash_cmd_o),
      .flash_addr_o(flash_addr_o),
      .flash_wdata_o(flash_wdata_o),
      .flash_byte_o(flash_byte_o)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence unlock_first_s;
      wr_dlo && sfr_wdata_i == `UNLOCK_FIRST && lock_reg == LK_PROT && unit_enable_i;
   endsequence
   sequence unlock_second_s;
      wr_dlo && sfr_wdata_i == `UNLOCK_SECOND && lock_reg == LK_STEP1 && unit_enable_i;
   endsequence

   enable_gate_a: assert property (!unit_enable_i |=> !start_reg || $past(drain)) // see [RQ1]
      else $error("launch while disabled");
   unlock_path_a: assert property (unlock_first_s ##[1:8] unlock_second_s |=> lock_reg == LK_OPEN) // see [RQ5]
      else $error("unlock sequence did not open");
   dead_sticky_a: assert property (lock_reg == LK_DEAD |=> lock_reg == LK_DEAD && !erase_acc && !write_acc) // see [RQ6]
      else $error("locked-out unit reopened");
   cancel_busy_a: assert property ((read_req || erase_req) && busy |=> !start_reg) // see [RQ11]
      else $error("request started while not ready");
   addr_step_a: assert property (read_acc && !wr_alo && !wr_ahi |=> addr_cur == $past(addr_inc)) // see [RQ4]
      else $error("address did not step");
   idle_hold_a: assert property (flash_req_o || ops.done |-> !cfg_view[`IDLE_BIT]) // see [RQ23]
      else $error("idle shown while busy");
   word_read_a: assert property (ops.done && ops.done_cmd == `TASK_READ && !op_byte_reg
      |=> {data_hi_reg, data_lo_reg} == $past(ops.rdata)) // see [RQ16]
      else $error("word read not returned");
   relock_a: assert property (relock && lock_reg == LK_OPEN && !wr_dlo && !wr_cfg
      |=> lock_reg == LK_PROT) // see [RQ24]
      else $error("unit not relocked");
   page_align_a: assert property (start_reg && cmd_reg == `TASK_PAGE |-> op_addr_reg[8:0] == 9'h000) // see [RQ22]
      else $error("page erase address not aligned");
endmodule

//--- flash_program_interface_bench.sv
// self-checking bench for the flash programming unit
// assumes the array model and the register header sit in this folder
`timescale 1ns/1ps
`include "flash_prog_unit_regs.svh"
module flash_program_interface_bench;
   import flash_prog_pkg::*;
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_count++; \
$display("FAIL %s exp %h got %h", nm, ex, gt); end end
   // ---------------------------------------------
   // signals and instances
   // ---------------------------------------------
   logic clk_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, unit_enable_i = 1'b1;
   byte_t sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, rv; // rv: last read value
   logic flash_done_i, flash_req_o, flash_byte_o, cap_byte, req_q = 1'b0;
   logic [1:0] flash_cmd_o, cap_cmd;
   logic [3:0] flash_clk_range_o;
   word_t flash_rdata_i, flash_addr_o, flash_wdata_o, cap_addr, cap_wd, e;
   int err_count = 0, n_checks = 0, n_ops = 0, n0;
   always #2.5 clk_i = ~clk_i;
   flash_program_interface u_dut (.clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
      .unit_enable_i, .flash_done_i, .flash_rdata_i, .sfr_rdata_o, .flash_req_o, .flash_cmd_o,
      .flash_addr_o, .flash_wdata_o, .flash_byte_o, .flash_clk_range_o);
   flash_array_model u_flash (.clk_i, .rst_i, .req_i(flash_req_o), .addr_i(flash_addr_o),
      .done_o(flash_done_i), .rdata_o(flash_rdata_i));
   // capture each request toward the array on its rising edge
   always @(posedge clk_i) begin
      req_q <= flash_req_o;
      if (flash_req_o && !req_q) begin
         n_ops++;
         cap_cmd <= flash_cmd_o;
         cap_addr <= flash_addr_o;
         cap_wd <= flash_wdata_o;
         cap_byte <= flash_byte_o;
      end
   end
   // ---------------------------------------------
   // register port tasks
   // ---------------------------------------------
   task wr(input byte_t a, input byte_t d);
      @(posedge clk_i);
      #1 sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(posedge clk_i);
      #1 sfr_wr_i = 1'b0;
   endtask
   task rd(input byte_t a);
      @(posedge clk_i);
      #1 sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      @(posedge clk_i);
      #1 sfr_rd_i = 1'b0;
      rv = sfr_rdata_o; // loaded on the strobe edge
   endtask
   task unlock;
      wr(`DATA_LO_OFS, 8'hAA);
      wr(`DATA_LO_OFS, 8'h55);
   endtask
   // idle must drop while busy, then come back within a bounded poll
   task wait_idle;
      rd(`CFG_OFS);
      `CHK("idle busy", 1'b0, rv[5])
      for (int i = 0; i < 40 && rv[5] !== 1'b1; i++) rd(`CFG_OFS);
      `CHK("idle done", 1'b1, rv[5])
   endtask
   task chk_op(input logic [1:0] c, input word_t a);
      `CHK("op count", n0 + 1, n_ops)
      `CHK("op cmd", c, cap_cmd)
      `CHK("op addr", a, cap_addr)
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      err_count++;
      give_verdict();
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      repeat (4) @(posedge clk_i);
      #1 rst_i = 1'b0;
      rd(`CFG_OFS);
      `CHK("cfg reset", 8'h34, rv)
      for (int a = 8'hEA; a <= 8'hEE; a++) begin
         rd(byte_t'(a));
         `CHK("reg reset", 8'h00, rv)
      end
      rd(8'hE0);
      `CHK("unmapped", 8'h00, rv)
      wr(`CLK_RANGE_OFS, 8'hFF);
      rd(`CLK_RANGE_OFS);
      `CHK("clk range", 8'h0F, rv)
      `CHK("clk out", 4'hF, flash_clk_range_o)
      // byte read, repeated request while busy is cancelled
      wr(`ADDR_HI_OFS, 8'hAB);
      wr(`ADDR_LO_OFS, 8'hCD);
      n0 = n_ops;
      wr(`CFG_OFS, 8'h04);
      wr(`CFG_OFS, 8'h04);
      wait_idle();
      chk_op(2'h0, 16'hABCD);
      `CHK("byte mode", 1'b1, cap_byte)
      e = 16'hABCD ^ 16'hC35A;
      rd(`DATA_LO_OFS);
      `CHK("byte data", e[7:0], rv)
      rd(`ADDR_LO_OFS);
      `CHK("addr step", 8'hCE, rv)
      // word read at word address 55E6
      wr(`ADDR_HI_OFS, 8'h55);
      wr(`ADDR_LO_OFS, 8'hE6);
      n0 = n_ops;
      wr(`CFG_OFS, 8'h00);
      wait_idle();
      chk_op(2'h0, 16'hABCC);
      `CHK("word mode", 1'b0, cap_byte)
      e = 16'hABCC ^ 16'hC35A;
      rd(`DATA_HI_OFS);
      `CHK("word hi", e[15:8], rv)
      rd(`DATA_LO_OFS);
      `CHK("word lo", e[7:0], rv)
      rd(`ADDR_LO_OFS);
      `CHK("word step", 8'hE7, rv)
      // page erase of page 64, then relock
      unlock();
      rd(`CFG_OFS);
      `CHK("lock open", 2'b10, rv[7:6])
      wr(`ADDR_LO_OFS, 8'h00);
      wr(`ADDR_HI_OFS, 8'h40);
      n0 = n_ops;
      wr(`CFG_OFS, 8'h02);
      wait_idle();
      chk_op(2'h2, 16'h8000);
      rd(`CFG_OFS);
      `CHK("relock", 2'b00, rv[7:6])
      // mass erase
      unlock();
      n0 = n_ops;
      wr(`CFG_OFS, 8'h01);
      wait_idle();
      chk_op(2'h1, 16'h0000);
      // word write launched by the data low write
      wr(`ADDR_LO_OFS, 8'h10);
      wr(`ADDR_HI_OFS, 8'h00);
      unlock();
      wr(`CFG_OFS, 8'h03);
      wr(`DATA_HI_OFS, 8'h12);
      n0 = n_ops;
      wr(`DATA_LO_OFS, 8'h34);
      wait_idle();
      chk_op(2'h3, 16'h0020);
      `CHK("write data", 16'h1234, cap_wd)
      rd(`ADDR_LO_OFS);
      `CHK("write step", 8'h11, rv)
      // byte write stream: the second write waits in the buffer, a third is cancelled
      wr(`CFG_OFS, 8'h07);
      unlock();
      n0 = n_ops;
      wr(`DATA_LO_OFS, 8'h5A);
      wr(`DATA_LO_OFS, 8'hA5);
      rd(`CFG_OFS);
      `CHK("buffer full", 1'b0, rv[4])
      wr(`DATA_LO_OFS, 8'h77);
      wait_idle();
      `CHK("stream ops", n0 + 2, n_ops)
      `CHK("stream addr", 16'h0012, cap_addr)
      `CHK("stream data", 8'hA5, cap_wd[7:0])
      rd(`ADDR_LO_OFS);
      `CHK("stream step", 8'h13, rv)
      // disabled unit starts nothing
      unit_enable_i = 1'b0;
      n0 = n_ops;
      wr(`CFG_OFS, 8'h04);
      repeat (12) @(posedge clk_i);
      `CHK("disabled", n0, n_ops)
      #1 unit_enable_i = 1'b1;
      // wrong second byte locks out until reset
      wr(`DATA_LO_OFS, 8'hAA);
      wr(`DATA_LO_OFS, 8'h11);
      rd(`CFG_OFS);
      `CHK("lock dead", 2'b11, rv[7:6])
      n0 = n_ops;
      wr(`CFG_OFS, 8'h02);
      repeat (12) @(posedge clk_i);
      `CHK("dead erase", n0, n_ops)
      #1 rst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 rst_i = 1'b0;
      rd(`CFG_OFS);
      `CHK("reset clears", 8'h34, rv)
      give_verdict();
   end
endmodule
